//--- logic/slc_pkg.sv
// constants for the serial link sideband clock and power block
package slc_pkg;
  // register byte offsets
  localparam logic [7:0] SLC_OFF_VERSION = 8'h00;
  localparam logic [7:0] SLC_OFF_CONTROL = 8'h04;
  localparam logic [7:0] SLC_OFF_STATUS = 8'h08;
  localparam logic [7:0] SLC_OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] SLC_OFF_IRQ_PENDING = 8'h14;
  localparam logic [7:0] SLC_OFF_IRQ_CFG_LO = 8'h40;
  localparam logic [7:0] SLC_OFF_IRQ_CFG_HI = 8'h44;
  // control register fields
  localparam int SLC_CTL_LOOPBACK = 0;
  localparam int SLC_CTL_IRQ_LOCAL = 1;
  localparam int SLC_CTL_PULLUP_DIS = 2;
  localparam int SLC_CTL_CLKDIR = 15;
  localparam int SLC_CTL_DIV_LSB = 16;
  localparam int SLC_CTL_DIV_W = 3;
  localparam int SLC_CTL_FASTPATH = 21;
  localparam logic [31:0] SLC_CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] SLC_CTL_WMASK = 32'h0027_8007;
  // per-input interrupt config byte
  localparam int SLC_ICFG_EN = 0;
  localparam int SLC_ICFG_POL = 1;
  localparam int SLC_ICFG_EDGE = 2;
  localparam int SLC_ICFG_VEC_LSB = 3;
  localparam int SLC_ICFG_VEC_W = 3;
  localparam logic [63:0] SLC_ICFG_RESET = 64'h0;
  localparam int SLC_NUM_IRQ = 8;
  // status register fields
  localparam int SLC_ST_FREE_LSB = 0;
  localparam int SLC_ST_RET_LSB = 8;
  localparam int SLC_ST_SER_BUSY = 16;
  localparam int SLC_ST_BUSY_REQ = 17;
  localparam int SLC_ST_HOST_BUSY = 18;
  localparam int SLC_ST_LINK_UP = 19;
  // command queue
  localparam logic [4:0] SLC_CMD_DEPTH = 5'h18;
  localparam logic [4:0] SLC_CMD_FULL_FREE = 5'h07;
  // stages of each reset release
  localparam int SLC_RST_STAGES = 2;
endpackage

//--- logic/slc_sideband.sv
// sideband clock, reset, interrupt and power logic of the serial link bridge
`timescale 1ns/10ps

// Summary of operation
// - divided clock period is ref times div+1
// - clock select high when divider is zero
// - full-rate clock output passes reference straight through
// - clock pad enable_n is inverse of clock direction
// - clock logic reset released on reference clock
// - io logic reset released on receive clock
// - bus reset pin synchronised before internal use
// - lane count set by LANES, default four, none tied off
// - enabled matching interrupt input sets vectored pending bit
// - level interrupt held while any status bit set
// - one-cycle pulse when bit cleared under level
// - version register returns ident and revision inputs
// - clock direction bit loads default at reset
// - command queue free count, 0x07 when full
// - return queue word count reported on output
// - control bit 21 mirrored to fast path
// - loopback sends receive lanes to transmit lanes
// - clock-run data zero, enable_n low when busy
// - serial busy, busy request, host busy outputs
// - clock pullup enabled only remote clock, not disabled
// - receive pullups enabled until link established
module slc_sideband
  import slc_pkg::*;
#(
  parameter int LANES = 4
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic bus_reset_n_in,
  input wire logic link_ref_clock_in,
  input wire logic link_rx_clock_in,
  output logic link_clock_full_out,
  output logic link_clock_div_out,
  output logic link_clock_select_out,
  output logic link_clock_oe_n_out,
  output logic clock_logic_reset_n_out,
  output logic io_logic_reset_n_out,
  input wire logic [LANES-1:0] serial_rx_lanes_in,
  input wire logic [LANES-1:0] tx_data_in,
  output logic [LANES-1:0] serial_tx_lanes_out,
  output logic [LANES-1:0] rx_data_out,
  input wire logic [SLC_NUM_IRQ-1:0] irq_inputs_in,
  output logic irq_pulse_out,
  output logic irq_level_out,
  input wire logic [15:0] part_ident_in,
  input wire logic [15:0] part_rev_in,
  input wire logic default_clock_dir_in,
  input wire logic [4:0] cmd_queue_used_in,
  output logic [4:0] cmd_queue_free_out,
  input wire logic [4:0] return_queue_count_in,
  output logic [4:0] return_queue_count_out,
  output logic tx_fast_path_out,
  output logic io_loopback_enable_out,
  input wire logic clock_run_in_n_in,
  output logic clock_run_out_n_out,
  output logic clock_run_oe_n_out,
  output logic clock_run_pullup_en_n_out,
  input wire logic serial_pending_in,
  input wire logic host_pending_in,
  input wire logic link_established_in,
  output logic serial_busy_out,
  output logic serial_busy_req_out,
  output logic host_bus_busy_out,
  output logic link_clock_pullup_en_n_out,
  output logic [LANES-1:0] rx_lane_pullup_en_n_out
);

  // pin vector: ref clk, rx clk, bus reset, clock run, interrupts, rx lanes
  localparam int NPIN = 4 + SLC_NUM_IRQ + LANES;
  localparam int P_REF = 0;
  localparam int P_RXC = 1;
  localparam int P_BRST = 2;
  localparam int P_CRUN = 3;
  localparam int P_IRQ = 4;
  localparam int P_LANE = 4 + SLC_NUM_IRQ;

  function automatic logic slc_addr_hit(input logic [7:0] a);
    logic hit;
    hit = 1'b0;
    if (a == SLC_OFF_VERSION) begin
      hit = 1'b1;
    end else if (a == SLC_OFF_CONTROL) begin
      hit = 1'b1;
    end else if (a == SLC_OFF_STATUS) begin
      hit = 1'b1;
    end else if (a == SLC_OFF_IRQ_STATUS) begin
      hit = 1'b1;
    end else if (a == SLC_OFF_IRQ_PENDING) begin
      hit = 1'b1;
    end else if (a == SLC_OFF_IRQ_CFG_LO) begin
      hit = 1'b1;
    end else if (a == SLC_OFF_IRQ_CFG_HI) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  function automatic logic [31:0] slc_byte_mask(input logic [3:0] strb);
    return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  logic [NPIN-1:0] pin_s3_r;
  logic [NPIN-1:0] pin_f_r;
  logic [NPIN-1:0] pin_fd_r;
  logic rst;
  logic ref_rise;
  logic rx_rise;
  logic [SLC_RST_STAGES-1:0] clk_rst_r;
  logic [SLC_RST_STAGES-1:0] io_rst_r;
  logic [31:0] ctl_r;
  logic [63:0] icfg_r;
  logic [SLC_NUM_IRQ-1:0] irq_stat_r;
  logic [SLC_NUM_IRQ-1:0] irq_stat_nxt;
  logic [SLC_NUM_IRQ-1:0] irq_act;
  logic [SLC_NUM_IRQ-1:0] irq_act_prev_r;
  logic [SLC_NUM_IRQ-1:0] irq_set;
  logic [SLC_NUM_IRQ-1:0] irq_clr;
  logic [SLC_NUM_IRQ-1:0] irq_sw_set;
  logic [SLC_CTL_DIV_W-1:0] div_val;
  logic [SLC_CTL_DIV_W-1:0] div_cnt_r;
  logic [SLC_CTL_DIV_W-1:0] div_cnt_nxt;
  logic [31:0] wmask;
  logic [31:0] rd_mux;
  logic wr_acc;
  logic [31:0] status_word;

  // pin synchronisers with agreement filter
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      logic pin_raw;
      if (gi == P_REF) begin : g_ref
        assign pin_raw = link_ref_clock_in;
      end else if (gi == P_RXC) begin : g_rxc
        assign pin_raw = link_rx_clock_in;
      end else if (gi == P_BRST) begin : g_brst
        assign pin_raw = bus_reset_n_in;
      end else if (gi == P_CRUN) begin : g_crun
        assign pin_raw = clock_run_in_n_in;
      end else if (gi < P_LANE) begin : g_irq
        assign pin_raw = irq_inputs_in[gi-P_IRQ];
      end else begin : g_lane
        assign pin_raw = serial_rx_lanes_in[gi-P_LANE];
      end
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          pin_s1_r[gi] <= 1'b0;
          pin_s2_r[gi] <= 1'b0;
          pin_s3_r[gi] <= 1'b0;
          pin_f_r[gi] <= 1'b0;
          pin_fd_r[gi] <= 1'b0;
        end else begin
          pin_s1_r[gi] <= pin_raw;
          pin_s2_r[gi] <= pin_s1_r[gi];
          pin_s3_r[gi] <= pin_s2_r[gi];
          if (pin_s2_r[gi] == pin_s3_r[gi]) begin
            pin_f_r[gi] <= pin_s2_r[gi];
          end
          pin_fd_r[gi] <= pin_f_r[gi];
        end
      end
    end
  endgenerate

  assign rst = srst_in | ~pin_f_r[P_BRST];
  assign ref_rise = pin_f_r[P_REF] & ~pin_fd_r[P_REF];
  assign rx_rise = pin_f_r[P_RXC] & ~pin_fd_r[P_RXC];

  // reset releases counted on link clock edges
  always_ff @(posedge clk_in) begin
    if (rst) begin
      clk_rst_r <= '0;
    end else if (ref_rise) begin
      clk_rst_r <= {clk_rst_r[SLC_RST_STAGES-2:0], 1'b1};
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      io_rst_r <= '0;
    end else if (rx_rise) begin
      io_rst_r <= {io_rst_r[SLC_RST_STAGES-2:0], 1'b1};
    end
  end

  assign clock_logic_reset_n_out = clk_rst_r[SLC_RST_STAGES-1] & ~rst;
  assign io_logic_reset_n_out = io_rst_r[SLC_RST_STAGES-1] & ~rst;

  // apb slave: zero wait, error on unmapped
  assign wr_acc = psel_in & penable_in & pwrite_in & slc_addr_hit(paddr_in);
  assign wmask = slc_byte_mask(pstrb_in);
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~slc_addr_hit(paddr_in);

  always_ff @(posedge clk_in) begin
    if (rst) begin
      ctl_r <= SLC_CTL_RESET;
      ctl_r[SLC_CTL_CLKDIR] <= default_clock_dir_in;
    end else if (wr_acc && paddr_in == SLC_OFF_CONTROL) begin
      ctl_r <= (ctl_r & ~(wmask & SLC_CTL_WMASK)) | (pwdata_in & wmask & SLC_CTL_WMASK);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      icfg_r <= SLC_ICFG_RESET;
    end else if (wr_acc && paddr_in == SLC_OFF_IRQ_CFG_LO) begin
      icfg_r[31:0] <= (icfg_r[31:0] & ~wmask) | (pwdata_in & wmask);
    end else if (wr_acc && paddr_in == SLC_OFF_IRQ_CFG_HI) begin
      icfg_r[63:32] <= (icfg_r[63:32] & ~wmask) | (pwdata_in & wmask);
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[SLC_ST_FREE_LSB +: 5] = cmd_queue_free_out;
    status_word[SLC_ST_RET_LSB +: 5] = return_queue_count_out;
    status_word[SLC_ST_SER_BUSY] = serial_busy_out;
    status_word[SLC_ST_BUSY_REQ] = serial_busy_req_out;
    status_word[SLC_ST_HOST_BUSY] = host_bus_busy_out;
    status_word[SLC_ST_LINK_UP] = link_established_in;
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr_in == SLC_OFF_VERSION) begin
      rd_mux = {part_rev_in, part_ident_in};
    end else if (paddr_in == SLC_OFF_CONTROL) begin
      rd_mux = ctl_r;
    end else if (paddr_in == SLC_OFF_STATUS) begin
      rd_mux = status_word;
    end else if (paddr_in == SLC_OFF_IRQ_STATUS || paddr_in == SLC_OFF_IRQ_PENDING) begin
      rd_mux = {24'h00_0000, irq_stat_r};
    end else if (paddr_in == SLC_OFF_IRQ_CFG_LO) begin
      rd_mux = icfg_r[31:0];
    end else if (paddr_in == SLC_OFF_IRQ_CFG_HI) begin
      rd_mux = icfg_r[63:32];
    end
  end

  // read data captured in setup phase
  always_ff @(posedge clk_in) begin
    if (rst) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_out <= rd_mux;
    end
  end

  // interrupt inputs
  generate
    for (gi = 0; gi < SLC_NUM_IRQ; gi++) begin : g_irq_act
      logic lvl;
      assign lvl = pin_f_r[P_IRQ+gi];
      assign irq_act[gi] = icfg_r[gi*8+SLC_ICFG_POL] ? ~lvl : lvl;
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (rst) begin
      irq_act_prev_r <= '0;
    end else begin
      irq_act_prev_r <= irq_act;
    end
  end

  always_comb begin
    logic hit;
    logic [SLC_ICFG_VEC_W-1:0] vec;
    hit = 1'b0;
    vec = '0;
    irq_set = '0;
    for (int i = 0; i < SLC_NUM_IRQ; i++) begin
      vec = icfg_r[i*8+SLC_ICFG_VEC_LSB +: SLC_ICFG_VEC_W];
      if (icfg_r[i*8+SLC_ICFG_EDGE]) begin
        hit = irq_act[i] & ~irq_act_prev_r[i];
      end else begin
        hit = irq_act[i];
      end
      if (icfg_r[i*8+SLC_ICFG_EN] && hit) begin
        irq_set[vec] = 1'b1;
      end
    end
  end

  assign irq_clr = (wr_acc && paddr_in == SLC_OFF_IRQ_STATUS) ? pwdata_in[SLC_NUM_IRQ-1:0] : '0;
  assign irq_sw_set = (wr_acc && paddr_in == SLC_OFF_IRQ_PENDING) ? pwdata_in[SLC_NUM_IRQ-1:0] : '0;
  // set wins over a same-cycle clear
  assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set | irq_sw_set;

  always_ff @(posedge clk_in) begin
    if (rst) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      irq_level_out <= 1'b0;
      irq_pulse_out <= 1'b0;
    end else begin
      irq_level_out <= ctl_r[SLC_CTL_IRQ_LOCAL] & (|irq_stat_nxt);
      irq_pulse_out <= ctl_r[SLC_CTL_IRQ_LOCAL] & irq_level_out & (|(irq_clr & irq_stat_r));
    end
  end

  // clock generation
  assign div_val = ctl_r[SLC_CTL_DIV_LSB +: SLC_CTL_DIV_W];
  assign link_clock_full_out = link_ref_clock_in;
  assign div_cnt_nxt = (div_cnt_r >= div_val) ? '0 : div_cnt_r + 3'h1;

  always_ff @(posedge clk_in) begin
    if (!clock_logic_reset_n_out) begin
      div_cnt_r <= '0;
      link_clock_div_out <= 1'b0;
    end else if (ref_rise) begin
      div_cnt_r <= div_cnt_nxt;
      link_clock_div_out <= (div_val != '0) && (div_cnt_nxt <= (div_val >> 1));
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst) begin
      link_clock_select_out <= 1'b1;
      link_clock_oe_n_out <= 1'b1;
      link_clock_pullup_en_n_out <= 1'b1;
      tx_fast_path_out <= 1'b0;
      io_loopback_enable_out <= 1'b0;
    end else begin
      link_clock_select_out <= (div_val == '0);
      link_clock_oe_n_out <= ~ctl_r[SLC_CTL_CLKDIR];
      link_clock_pullup_en_n_out <= ctl_r[SLC_CTL_CLKDIR] | ctl_r[SLC_CTL_PULLUP_DIS];
      tx_fast_path_out <= ctl_r[SLC_CTL_FASTPATH];
      io_loopback_enable_out <= ctl_r[SLC_CTL_LOOPBACK];
    end
  end

  // serial lanes
  always_ff @(posedge clk_in) begin
    if (rst) begin
      serial_tx_lanes_out <= '0;
      rx_data_out <= '0;
      rx_lane_pullup_en_n_out <= '0;
    end else begin
      rx_data_out <= pin_f_r[P_LANE +: LANES];
      if (ctl_r[SLC_CTL_LOOPBACK]) begin
        serial_tx_lanes_out <= pin_f_r[P_LANE +: LANES];
      end else begin
        serial_tx_lanes_out <= tx_data_in;
      end
      rx_lane_pullup_en_n_out <= {LANES{link_established_in}};
    end
  end

  // queue status and power management
  always_ff @(posedge clk_in) begin
    if (rst) begin
      cmd_queue_free_out <= SLC_CMD_DEPTH;
      return_queue_count_out <= 5'h00;
      serial_busy_out <= 1'b0;
      serial_busy_req_out <= 1'b0;
      host_bus_busy_out <= 1'b0;
      clock_run_oe_n_out <= 1'b1;
    end else begin
      if (cmd_queue_used_in >= SLC_CMD_DEPTH) begin
        cmd_queue_free_out <= SLC_CMD_FULL_FREE;
      end else begin
        cmd_queue_free_out <= SLC_CMD_DEPTH - cmd_queue_used_in;
      end
      return_queue_count_out <= return_queue_count_in;
      serial_busy_out <= serial_pending_in;
      serial_busy_req_out <= serial_pending_in | ~pin_f_r[P_CRUN];
      host_bus_busy_out <= host_pending_in;
      clock_run_oe_n_out <= ~serial_pending_in;
    end
  end

  assign clock_run_out_n_out = 1'b0;
  assign clock_run_pullup_en_n_out = 1'b1;

endmodule

//--- dv/slc_sideband_checker.sv
// port assertions for the sideband block
`timescale 1ns/10ps
module slc_sideband_checker
  import slc_pkg::*;
#(
  parameter int LANES = 4
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [7:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic bus_reset_n_in,
  input wire logic link_ref_clock_in,
  input wire logic link_clock_full_out,
  input wire logic clock_logic_reset_n_out,
  input wire logic io_logic_reset_n_out,
  input wire logic irq_pulse_out,
  input wire logic [4:0] cmd_queue_used_in,
  input wire logic [4:0] cmd_queue_free_out,
  input wire logic [4:0] return_queue_count_in,
  input wire logic [4:0] return_queue_count_out,
  input wire logic clock_run_out_n_out,
  input wire logic clock_run_oe_n_out,
  input wire logic serial_pending_in,
  input wire logic host_pending_in,
  input wire logic link_established_in,
  input wire logic serial_busy_out,
  input wire logic serial_busy_req_out,
  input wire logic host_bus_busy_out,
  input wire logic [LANES-1:0] rx_lane_pullup_en_n_out
);
  logic [2:0] live_r;
  // settle cycles after any reset
  always_ff @(posedge clk_in) begin
    if (srst_in || !bus_reset_n_in) begin
      live_r <= 3'h0;
    end else if (live_r != 3'h7) begin
      live_r <= live_r + 3'h1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in || live_r != 3'h7);
  full_clock_a: assert property (link_clock_full_out == link_ref_clock_in) else $error("full clock differs");
  reset_hold_a: assert property (disable iff (1'b0) $past(srst_in) && srst_in |->
    !clock_logic_reset_n_out && !io_logic_reset_n_out) else $error("reset outputs released in reset");
  bus_reset_a: assert property (disable iff (1'b0) !bus_reset_n_in [*8] |->
    !clock_logic_reset_n_out && !io_logic_reset_n_out) else $error("bus reset not passed on");
  busy_track_a: assert property (serial_busy_out == $past(serial_pending_in) &&
    host_bus_busy_out == $past(host_pending_in)) else $error("busy outputs wrong");
  busy_req_a: assert property (serial_pending_in |=> serial_busy_req_out) else $error("busy request missing");
  crun_drive_a: assert property (clock_run_out_n_out == 1'b0 &&
    clock_run_oe_n_out == !$past(serial_pending_in)) else $error("clock run drive wrong");
  rx_pullup_a: assert property (rx_lane_pullup_en_n_out == {LANES{$past(link_established_in)}})
    else $error("receive pullups wrong");
  ret_count_a: assert property (return_queue_count_out == $past(return_queue_count_in))
    else $error("return count wrong");
  free_full_a: assert property (cmd_queue_used_in == SLC_CMD_DEPTH |=>
    cmd_queue_free_out == SLC_CMD_FULL_FREE) else $error("full free count wrong");
  free_part_a: assert property (cmd_queue_used_in < SLC_CMD_DEPTH |=>
    cmd_queue_free_out == SLC_CMD_DEPTH - $past(cmd_queue_used_in)) else $error("free count wrong");
  pulse_cause_a: assert property (irq_pulse_out |-> $past(psel_in && penable_in && pwrite_in &&
    paddr_in == SLC_OFF_IRQ_STATUS)) else $error("pulse without clear");
  pulse_single_a: assert property (irq_pulse_out |=> !irq_pulse_out) else $error("pulse too long");
endmodule

bind slc_sideband slc_sideband_checker #(.LANES(LANES)) slc_sideband_checker_inst (.*);

//--- dv/slc_peer_model.sv
// remote peer and board pads: clocks, lanes, shared clock-run line
`timescale 1ns/10ps
module slc_peer_model (
  input wire logic rx_on_in,
  input wire logic [3:0] lanes_val_in,
  input wire logic peer_req_in,
  input wire logic dev_oe_n_in,
  input wire logic dev_out_n_in,
  output logic ref_clk_out,
  output logic rx_clk_out,
  output logic [3:0] lanes_out,
  output logic clock_run_n_out
);
  initial begin
    ref_clk_out = 1'b0;
    rx_clk_out = 1'b0;
  end
  always #20 ref_clk_out = ~ref_clk_out;
  // receive clock stands low while stopped
  always #24 rx_clk_out = rx_on_in ? ~rx_clk_out : 1'b0;
  // all four lanes in use, none left to tie off
  assign lanes_out = lanes_val_in;
  // pulled-up shared line, either side may pull it low
  assign clock_run_n_out = !(peer_req_in || (!dev_oe_n_in && !dev_out_n_in));
endmodule

//--- dv/tb.sv
// self-checking testbench for the sideband block
`timescale 1ns/10ps
module tb;
  import slc_pkg::*;
  localparam logic [15:0] ID_VAL = 16'h5A3C; // arbitrary value
  localparam logic [15:0] REV_VAL = 16'h0102; // arbitrary value
  localparam int REF_NS = 40;
  logic clk_in = 1'b0, srst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out;
  logic [3:0] pstrb_in = 4'hF, tx_data_in = 4'h0, lanes_val = 4'h0;
  logic [3:0] serial_rx_lanes_in, serial_tx_lanes_out, rx_data_out, rx_lane_pullup_en_n_out;
  logic [7:0] irq_inputs_in = 8'h02;
  logic [15:0] part_ident_in = ID_VAL, part_rev_in = REV_VAL;
  logic [4:0] cmd_queue_used_in = 5'h00, return_queue_count_in = 5'h00, cmd_queue_free_out, return_queue_count_out;
  logic bus_reset_n_in = 1'b1, rx_on = 1'b1, peer_req = 1'b0, default_clock_dir_in = 1'b1, slv_seen;
  logic serial_pending_in = 1'b0, host_pending_in = 1'b0, link_established_in = 1'b0;
  logic pready_out, pslverr_out, link_ref_clock_in, link_rx_clock_in, link_clock_full_out, link_clock_div_out;
  logic link_clock_select_out, link_clock_oe_n_out, clock_logic_reset_n_out, io_logic_reset_n_out;
  logic irq_pulse_out, irq_level_out, tx_fast_path_out, io_loopback_enable_out, clock_run_in_n_in;
  logic clock_run_out_n_out, clock_run_oe_n_out, clock_run_pullup_en_n_out, serial_busy_out;
  logic serial_busy_req_out, host_bus_busy_out, link_clock_pullup_en_n_out;
  int n_fail = 0, check_count = 0, cyc = 0;

  slc_sideband slc_sideband_inst (.*);
  slc_peer_model slc_peer_model_inst (.rx_on_in(rx_on), .lanes_val_in(lanes_val), .peer_req_in(peer_req),
    .dev_oe_n_in(clock_run_oe_n_out), .dev_out_n_in(clock_run_out_n_out), .ref_clk_out(link_ref_clock_in),
    .rx_clk_out(link_rx_clock_in), .lanes_out(serial_rx_lanes_in), .clock_run_n_out(clock_run_in_n_in));

  always #2.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      $display("[ERR] %0t run timed out", $time);
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_on(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 400) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 400) begin
      n_fail++;
      $display("[ERR] %0t wait ran out", $time);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n == 50) begin
      n_fail++;
      $display("[ERR] %0t bus wait ran out", $time);
    end
    q = prdata_out;
    slv_seen = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic t_ctl;
    chk(32'(rx_lane_pullup_en_n_out), 32'h0);
    rd(SLC_OFF_VERSION, {REV_VAL, ID_VAL});
    rd(8'h0C, 32'h0);
    chk(32'(slv_seen), 32'h1);
    rd(SLC_OFF_CONTROL, 32'h0000_8000);
    chk(32'({link_clock_oe_n_out, link_clock_pullup_en_n_out}), 32'h1);
    lanes_val <= 4'hA;
    wr(SLC_OFF_CONTROL, 32'h0020_0001);
    repeat (6) @(posedge clk_in);
    chk(32'({link_clock_oe_n_out, link_clock_pullup_en_n_out}), 32'h2);
    chk(32'({tx_fast_path_out, io_loopback_enable_out}), 32'h3);
    chk(32'(serial_tx_lanes_out), 32'hA);
    lanes_val <= 4'h5;
    repeat (6) @(posedge clk_in);
    chk(32'(serial_tx_lanes_out), 32'h5);
    chk(32'({rx_data_out, clock_run_pullup_en_n_out}), 32'hB);
    tx_data_in <= 4'h3;
    wr(SLC_OFF_CONTROL, 32'h0000_0004);
    repeat (3) @(posedge clk_in);
    chk(32'({link_clock_pullup_en_n_out, tx_fast_path_out, io_loopback_enable_out}), 32'h4);
    chk(32'(serial_tx_lanes_out), 32'h3);
    $display("control test done");
  endtask

  task automatic t_div;
    realtime t0;
    for (int d = 0; d < 8; d++) begin
      wr(SLC_OFF_CONTROL, 32'(d) << SLC_CTL_DIV_LSB);
      repeat (4) @(posedge clk_in);
      chk(32'(link_clock_select_out), 32'(d == 0));
      if (d != 0) begin
        repeat (2) begin
          wait_on(link_clock_div_out, 1'b0);
          wait_on(link_clock_div_out, 1'b1);
        end
        t0 = $realtime;
        wait_on(link_clock_div_out, 1'b0);
        wait_on(link_clock_div_out, 1'b1);
        chk(32'(int'($realtime - t0)), 32'(REF_NS * (d + 1)));
      end else begin
        chk(32'(link_clock_div_out), 32'h0);
      end
    end
    $display("divider test done");
  endtask

  task automatic pulse_chk(input logic lvl);
    logic seen;
    seen = 1'b0;
    repeat (3) begin
      @(posedge clk_in);
      seen = seen | irq_pulse_out;
    end
    chk(32'({seen, irq_level_out}), {30'h0, 1'b1, lvl});
  endtask

  task automatic t_irq;
    wr(SLC_OFF_CONTROL, 32'h0000_0002);
    wr(SLC_OFF_IRQ_CFG_LO, 32'h0000_1729);
    irq_inputs_in <= 8'h03;
    wait_on(irq_level_out, 1'b1);
    irq_inputs_in <= 8'h00;
    repeat (8) @(posedge clk_in);
    rd(SLC_OFF_IRQ_STATUS, 32'h24);
    wr(SLC_OFF_IRQ_STATUS, 32'h20);
    pulse_chk(1'b1);
    wr(SLC_OFF_IRQ_STATUS, 32'h04);
    pulse_chk(1'b0);
    $display("interrupt test done");
  endtask

  task automatic t_power;
    logic [4:0] uv [4] = '{5'h00, 5'h0A, 5'h17, 5'h18};
    serial_pending_in <= 1'b1;
    host_pending_in <= 1'b1;
    link_established_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk(32'({serial_busy_out, serial_busy_req_out, host_bus_busy_out}), 32'h7);
    chk(32'({clock_run_oe_n_out, clock_run_out_n_out}), 32'h0);
    chk(32'(rx_lane_pullup_en_n_out), 32'hF);
    serial_pending_in <= 1'b0;
    host_pending_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk(32'({serial_busy_out, serial_busy_req_out, host_bus_busy_out, clock_run_oe_n_out}), 32'h1);
    peer_req <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk(32'({serial_busy_out, serial_busy_req_out}), 32'h1);
    peer_req <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      cmd_queue_used_in <= uv[i];
      return_queue_count_in <= uv[i];
      repeat (3) @(posedge clk_in);
      chk(32'(cmd_queue_free_out), 32'((uv[i] == 5'h18) ? 5'h07 : 5'h18 - uv[i]));
      chk(32'(return_queue_count_out), 32'(uv[i]));
    end
    $display("power test done");
  endtask

  task automatic t_busrst;
    bus_reset_n_in <= 1'b0;
    rx_on <= 1'b0;
    repeat (10) @(posedge clk_in);
    chk(32'({clock_logic_reset_n_out, io_logic_reset_n_out}), 32'h0);
    bus_reset_n_in <= 1'b1;
    repeat (40) @(posedge clk_in);
    chk(32'({clock_logic_reset_n_out, io_logic_reset_n_out}), 32'h2);
    rx_on <= 1'b1;
    wait_on(io_logic_reset_n_out, 1'b1);
    rd(SLC_OFF_CONTROL, 32'h0000_8000);
    $display("bus reset test done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_in);
    chk(32'({link_clock_select_out, clock_logic_reset_n_out}), 32'h2);
    chk(32'({io_logic_reset_n_out, irq_level_out}), 32'h0);
    chk(32'(cmd_queue_free_out), 32'h18);
    @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    t_ctl();
    t_div();
    t_irq();
    t_power();
    t_busrst();
    report_and_stop();
  end
endmodule
